// ---- hdl/scdl_map.vh ----
// constants for the serial control dac loader
//
// Overview of operation
// - while enable low, capture one 12-bit word, one bit per serial clock rise
// - first bit of each word selects which control dac output updates
// - next bit sets output mode on words to dac a; two bits ignored; final eight bits are the dac value
// - enable falling edge starts a new loading cycle
// - both outputs hold until enable rises; then only selected output updates
// - enable high keeps loader disabled; serial clock edges shift nothing
// - test pin low: output mode follows the serially programmed function
// - test pin high: output mode forced to normal
// - grounded mode forces video outputs and dac a to ground; normal follows inputs
`ifndef SCDL_MAP_VH
`define SCDL_MAP_VH
`define SCDL_WORD_BITS 12
`define SCDL_DAC_BITS 8
`define SCDL_SEL_BIT 11
`define SCDL_MODE_BIT 10
`define SCDL_DAC_MSB 7
`define SCDL_DAC_RESET 8'h00
`define SCDL_WORD_RESET 12'h000
`define SCDL_MODE_NORMAL 1'b0
`define SCDL_MODE_GROUNDED 1'b1
`define SCDL_PIN_IDLE 1'b0
`define SCDL_LOAD_IDLE 1'b1
`define SCDL_FLAG_RESET 1'b0
`endif

// ---- hdl/scdl_sync.v ----
// two-flop synchroniser with edge detection on the synced level
`timescale 1ns/1ps
module scdl_sync #(
   parameter RESET_VAL = 1'b0
) (
   input wire i_ref_clk, // system clock
   input wire i_sys_rst, // synchronous reset, high
   input wire i_async,   // raw pin
   output wire o_level,  // synchronised level
   output wire o_rise,   // one-cycle pulse on rise
   output wire o_fall    // one-cycle pulse on fall
);
   reg meta_q;
   reg sync_q;
   reg prev_q;
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
         prev_q <= RESET_VAL;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign o_level = sync_q;
   assign o_rise = sync_q & ~prev_q;
   assign o_fall = ~sync_q & prev_q;
endmodule // scdl_sync

// ---- hdl/scdl_loader.v ----
// serial loader for two 8-bit control dacs with output mode control
`timescale 1ns/1ps
`include "scdl_map.vh"
module scdl_loader #(
   parameter WORD_BITS = `SCDL_WORD_BITS,
   parameter DAC_BITS = `SCDL_DAC_BITS
) (
   input wire i_ref_clk,                     // 20 MHz system clock
   input wire i_sys_rst,                     // synchronous reset, high
   input wire i_serial_clk,                  // serial shift clock pin
   input wire i_serial_data_in,              // serial data pin
   input wire i_load_enable_n,               // load enable pin, low active
   input wire i_test_mode_pin,               // forces normal mode when high
   output reg [DAC_BITS-1:0] o_control_dac_out_a, // dac a code
   output reg [DAC_BITS-1:0] o_control_dac_out_b, // dac b code
   output reg o_grounded_mode,               // effective output mode, high grounded
   output reg o_dac_a_grounded,              // dac a forced to ground
   output wire o_loading                     // loader active
);
   wire clk_rise;
   wire data_lvl;
   wire load_n_lvl;
   wire load_start;
   wire load_done;
   wire test_lvl;
   wire shift_now;
   reg [WORD_BITS-1:0] shift_q;
   reg [WORD_BITS-1:0] shift_d;
   reg mode_q;
   reg mode_d;
   reg [DAC_BITS-1:0] dac_a_d;
   reg [DAC_BITS-1:0] dac_b_d;
   reg eff_mode;
   reg grounded_d;
   reg dac_a_gnd_d;

   // shift one bit in at the bottom
   function [WORD_BITS-1:0] shift_in;
      input [WORD_BITS-1:0] word;
      input bit_in;
      begin
         shift_in = {word[WORD_BITS-2:0], bit_in};
      end
   endfunction

   // output selector of a word
   function sel_of;
      input [WORD_BITS-1:0] word;
      begin
         sel_of = word[`SCDL_SEL_BIT];
      end
   endfunction

   // mode request of a word
   function mode_of;
      input [WORD_BITS-1:0] word;
      begin
         mode_of = word[`SCDL_MODE_BIT];
      end
   endfunction

   // dac code of a word
   function [DAC_BITS-1:0] code_of;
      input [WORD_BITS-1:0] word;
      begin
         code_of = word[`SCDL_DAC_MSB:0];
      end
   endfunction

   // grounded test of a mode value
   function is_grounded;
      input mode;
      begin
         is_grounded = (mode == `SCDL_MODE_GROUNDED);
      end
   endfunction

   // every pin passes two flops
   scdl_sync #(.RESET_VAL(`SCDL_PIN_IDLE)) u_clk (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_serial_clk),
      .o_level(),
      .o_rise(clk_rise),
      .o_fall()
   );

   scdl_sync #(.RESET_VAL(`SCDL_PIN_IDLE)) u_data (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_serial_data_in),
      .o_level(data_lvl),
      .o_rise(),
      .o_fall()
   );

   scdl_sync #(.RESET_VAL(`SCDL_LOAD_IDLE)) u_load (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_load_enable_n),
      .o_level(load_n_lvl),
      .o_rise(load_done),
      .o_fall(load_start)
   );

   scdl_sync #(.RESET_VAL(`SCDL_PIN_IDLE)) u_test (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_test_mode_pin),
      .o_level(test_lvl),
      .o_rise(),
      .o_fall()
   );

   assign o_loading = ~load_n_lvl;
   assign shift_now = ~load_n_lvl & clk_rise;

   always @* begin
      shift_d = shift_q;
      if (load_start) begin
         shift_d = `SCDL_WORD_RESET;
      end
      if (shift_now) begin
         shift_d = shift_in(shift_d, data_lvl);
      end
   end

   always @* begin
      dac_a_d = o_control_dac_out_a;
      if (load_done & ~sel_of(shift_q)) begin
         dac_a_d = code_of(shift_q);
      end
   end

   always @* begin
      dac_b_d = o_control_dac_out_b;
      if (load_done & sel_of(shift_q)) begin
         dac_b_d = code_of(shift_q);
      end
   end

   always @* begin
      mode_d = mode_q;
      // function set by words to a
      if (load_done & ~sel_of(shift_q)) begin
         mode_d = mode_of(shift_q);
      end
   end

   always @* begin
      if (test_lvl) begin
         eff_mode = `SCDL_MODE_NORMAL;
      end else begin
         eff_mode = mode_q;
      end
   end

   always @* begin
      grounded_d = is_grounded(eff_mode);
      dac_a_gnd_d = is_grounded(eff_mode);
   end

   // registered state and outputs
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         shift_q <= `SCDL_WORD_RESET;
      end else begin
         shift_q <= shift_d;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         mode_q <= `SCDL_MODE_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_control_dac_out_a <= `SCDL_DAC_RESET;
      end else begin
         o_control_dac_out_a <= dac_a_d;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_control_dac_out_b <= `SCDL_DAC_RESET;
      end else begin
         o_control_dac_out_b <= dac_b_d;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_grounded_mode <= `SCDL_MODE_NORMAL;
      end else begin
         o_grounded_mode <= grounded_d;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_dac_a_grounded <= `SCDL_FLAG_RESET;
      end else begin
         o_dac_a_grounded <= dac_a_gnd_d;
      end
   end
endmodule // scdl_loader

// ---- bench/scdl_host_model.sv ----
// serial host driving the loader pins
`timescale 1ns/1ps
module scdl_host_model (
   output logic o_sclk, // shift clock
   output logic o_data, // data
   output logic o_en_n // load enable
);
   initial begin
      o_sclk = 0;
      o_data = 0;
      o_en_n = 1;
   end
   task automatic send(input logic [15:0] w, input int n);
      o_en_n = 0;
      for (int i = n - 1; i >= 0; i--) begin
         o_data = w[i];
         #100 o_sclk = 1;
         #200 o_sclk = 0;
         #100;
      end
      o_en_n = 1;
      o_data = ~o_data;
   endtask
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         o_data = ~o_data;
         #100 o_sclk = 1;
         #200 o_sclk = 0;
         #100;
      end
   endtask
endmodule // scdl_host_model

// ---- bench/scdl_loader_properties.sv ----
// port assertions for the loader
`timescale 1ns/1ps
module scdl_loader_properties #(parameter DAC_BITS = 8) (
   input wire i_ref_clk, // clock
   input wire i_sys_rst, // reset
   input wire i_load_enable_n, // enable
   input wire i_test_mode_pin, // test
   input wire [DAC_BITS-1:0] o_control_dac_out_a, // dac a
   input wire [DAC_BITS-1:0] o_control_dac_out_b, // dac b
   input wire o_grounded_mode, // mode
   input wire o_dac_a_grounded, // ground a
   input wire o_loading // busy
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   a_dac_a_update: assert property ($changed(o_control_dac_out_a) |->
      !$past(o_loading) && $past(o_loading, 2)) else $error("dac a");
   a_dac_b_update: assert property ($changed(o_control_dac_out_b) |->
      !$past(o_loading) && $past(o_loading, 2)) else $error("dac b");
   a_one_output: assert property (!($changed(o_control_dac_out_a)
      && $changed(o_control_dac_out_b))) else $error("both moved");
   a_loading_follow: assert property (o_loading == !$past(i_load_enable_n, 2))
      else $error("loading");
   a_idle_no_load: assert property (i_load_enable_n [*8] |=> !o_loading)
      else $error("idle");
   a_load_ends: assert property ($rose(i_load_enable_n) |-> ##2 !o_loading)
      else $error("end");
   a_test_normal: assert property (i_test_mode_pin [*8] |=> !o_grounded_mode)
      else $error("test");
   a_ground_mirror: assert property (o_dac_a_grounded == o_grounded_mode)
      else $error("mirror");
endmodule // scdl_loader_properties
bind scdl_loader scdl_loader_properties #(.DAC_BITS(DAC_BITS)) chk (
   .i_ref_clk(i_ref_clk),
   .i_sys_rst(i_sys_rst),
   .i_load_enable_n(i_load_enable_n),
   .i_test_mode_pin(i_test_mode_pin),
   .o_control_dac_out_a(o_control_dac_out_a),
   .o_control_dac_out_b(o_control_dac_out_b),
   .o_grounded_mode(o_grounded_mode),
   .o_dac_a_grounded(o_dac_a_grounded),
   .o_loading(o_loading)
);

// ---- bench/scdl_loader_tb.sv ----
// testbench for the loader
`timescale 1ns/1ps
module scdl_loader_tb;
   logic i_ref_clk = 0, i_sys_rst = 1, i_test_mode_pin = 0, prog = 0;
   logic i_serial_clk, i_serial_data_in, i_load_enable_n;
   logic o_grounded_mode, o_dac_a_grounded, o_loading;
   logic [7:0] o_control_dac_out_a, o_control_dac_out_b, exp_a = 8'h00, exp_b = 8'h00;
   logic [11:0] k;
   logic [15:0] w;
   int error_cnt = 0, comparisons = 0, seed = 24706, n;
   always #25 i_ref_clk = ~i_ref_clk;
   scdl_host_model host (
      .o_sclk(i_serial_clk),
      .o_data(i_serial_data_in),
      .o_en_n(i_load_enable_n)
   );
   scdl_loader uut (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_serial_clk(i_serial_clk),
      .i_serial_data_in(i_serial_data_in),
      .i_load_enable_n(i_load_enable_n),
      .i_test_mode_pin(i_test_mode_pin),
      .o_control_dac_out_a(o_control_dac_out_a),
      .o_control_dac_out_b(o_control_dac_out_b),
      .o_grounded_mode(o_grounded_mode),
      .o_dac_a_grounded(o_dac_a_grounded),
      .o_loading(o_loading)
   );
   task check(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_sys_rst <= 0;
      for (int t = 0; t < 40; t++) begin
         @(posedge i_ref_clk);
         i_test_mode_pin <= (t % 4 == 3);
         w = 16'($random(seed));
         n = t < 4 ? 9 + t * 2 : 12;
         #5 host.stray(t % 3);
         repeat (8) @(posedge i_ref_clk);
         check({o_dac_a_grounded, o_control_dac_out_b}, {prog & !i_test_mode_pin, exp_b});
         #5 host.send(w, n);
         repeat (8) @(posedge i_ref_clk);
         k = 12'(w & ((17'h1 << n) - 17'h1));
         if (k[11]) exp_b = k[7:0];
         else begin
            exp_a = k[7:0];
            prog = k[10];
         end
         check({o_grounded_mode, o_control_dac_out_a}, {prog & !i_test_mode_pin, exp_a});
         check({o_dac_a_grounded, o_control_dac_out_b}, {prog & !i_test_mode_pin, exp_b});
         if (t == 20) begin
            i_sys_rst <= 1;
            repeat (4) @(posedge i_ref_clk);
            i_sys_rst <= 0;
            exp_a = 8'h00;
            exp_b = 8'h00;
            prog = 0;
            @(posedge i_ref_clk);
            check({o_grounded_mode, o_control_dac_out_a}, {1'b0, exp_a});
         end
      end
      give_verdict();
   end
endmodule // scdl_loader_tb
